// [core/cihlc_cpu_end.sv]
// Overview of operation
// - 256 four-byte vectors at bottom of memory
// - type byte times four gives pointer
// - non-maskable request beats maskable request
// - rising edge of nmi gives type 2
// - nmi source holds high over two clocks
// - latch nmi edge, serve at boundary
// - new edge after service start retriggers
// - nmi source free of glitches and bounce
// - maskable request level, gated by enable flag
// - maskable request sampled each clock before boundary
// - push old flags, clear enable on response
// - two acknowledge cycles, type read second
// - lock from T2 first to T2 second
// - local hold deferred until acknowledges end
// - held request re-served; flags pop restores enable
// - halt: one latch strobe or halt status
// - halt survives hold, indication reissued
// - halt left only by interrupt or reset
// - lock after prefix until instruction ends
// - request/grant during lock granted after lock
// - wait suspends while test high, no bus
// - test held low five clocks to release
`timescale 1ns/1ps
`default_nettype none
module cihlc_cpu_end (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  cihlc_if.cpu            bus,
  input  wire logic       min_mode_strap,
  input  wire logic       boundary,
  input  wire logic       lock_prefix,
  input  wire logic       lock_done,
  input  wire logic       halt_exec,
  input  wire logic       wait_exec,
  input  wire logic       if_set,
  input  wire logic       if_clear,
  input  wire logic       flags_pop,
  input  wire logic       popped_if,
  output logic            irq_valid,
  output logic [7:0]      irq_type,
  output logic [9:0]      vec_ptr,
  output logic            pushed_if,
  output logic            if_flag,
  output logic            halted,
  output logic            waiting,
  output logic            bus_released
);
  cihlc_pkg::cihlc_seq_type state_q;
  logic [1:0] t_q;
  logic [4:0] raw;
  logic [4:0] lvl;
  logic [4:0] rise;
  logic [4:0] fall;
  logic       min_q;
  logic       cap_q;
  logic       nmi_pend_q;
  logic       if_q;
  logic       pushed_if_q;
  logic       irq_valid_q;
  logic [7:0] irq_type_q;
  logic [9:0] vec_ptr_q;
  logic       ind_pend_q;
  logic       hold_ack_q;
  logic       rg_pend_q;
  logic       rg_gr_q;
  logic       rg_pulse_q;
  logic [2:0] guard_q;
  logic       lock_pref_q;
  logic       lock_ack_q;
  logic       waiting_q;
  logic       ack_busy;
  logic       lock_active;
  logic       take_pt;
  logic       nmi_take;
  logic       maskable_request_in_take;
  logic       halt_ind;
  logic       rg_edge;

  function automatic logic [9:0] vec_of(input logic [7:0] t);
    vec_of = 10'(t) << cihlc_pkg::VEC_SHIFT;
  endfunction

  assign raw = {bus.test_n, bus.request_grant_pin, bus.hold_req,
                bus.maskable_request_in, bus.nmi};

  // three-flop synchronisers; a level change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < cihlc_pkg::IN_W; gi++) begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lv_q;
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          s1_q <= cihlc_pkg::IN_IDLE[gi];
          s2_q <= cihlc_pkg::IN_IDLE[gi];
          s3_q <= cihlc_pkg::IN_IDLE[gi];
          lv_q <= cihlc_pkg::IN_IDLE[gi];
        end else begin
          s1_q <= raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lv_q <= s3_q;
          end
        end
      end
      assign lvl[gi]  = lv_q;
      assign rise[gi] = s2_q && s3_q && !lv_q;
      assign fall[gi] = !s2_q && !s3_q && lv_q;
    end
  endgenerate

  // strap caught on the first clock after reset release
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_q <= 1'b0;
      min_q <= 1'b0;
    end else if (!cap_q) begin
      cap_q <= 1'b1;
      min_q <= min_mode_strap;
    end
  end

  assign ack_busy    = (state_q == cihlc_pkg::SEQ_ACK1) || (state_q == cihlc_pkg::SEQ_ACK2);
  assign lock_active = lock_pref_q || lock_ack_q;
  assign take_pt     = (boundary || state_q == cihlc_pkg::SEQ_HALT || waiting_q) && !ack_busy;
  assign nmi_take    = take_pt && nmi_pend_q;
  assign maskable_request_in_take   = take_pt && !nmi_pend_q && lvl[cihlc_pkg::IX_MASKABLE_REQUEST_IN] && if_q
                       && !hold_ack_q && !rg_gr_q;
  assign halt_ind    = (state_q == cihlc_pkg::SEQ_HALT) && ind_pend_q && !hold_ack_q && !rg_gr_q;
  assign rg_edge     = fall[cihlc_pkg::IX_RG] && (guard_q == 3'h0);

  // response sequencer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= cihlc_pkg::SEQ_RUN;
      t_q     <= cihlc_pkg::T_FIRST;
    end else begin
      case (state_q)
        cihlc_pkg::SEQ_RUN: begin
          t_q <= cihlc_pkg::T_FIRST;
          if (maskable_request_in_take) begin
            state_q <= cihlc_pkg::SEQ_ACK1;
          end else if (halt_exec && !nmi_take) begin
            state_q <= cihlc_pkg::SEQ_HALT;
          end
        end
        cihlc_pkg::SEQ_HALT: begin
          t_q <= cihlc_pkg::T_FIRST;
          if (nmi_take) begin
            state_q <= cihlc_pkg::SEQ_RUN;
          end else if (maskable_request_in_take) begin
            state_q <= cihlc_pkg::SEQ_ACK1;
          end
        end
        cihlc_pkg::SEQ_ACK1: begin
          t_q <= t_q + 2'h1;
          if (t_q == cihlc_pkg::T_LAST) begin
            state_q <= cihlc_pkg::SEQ_ACK2;
          end
        end
        cihlc_pkg::SEQ_ACK2: begin
          t_q <= t_q + 2'h1;
          if (t_q == cihlc_pkg::T_LAST) begin
            state_q <= cihlc_pkg::SEQ_RUN;
          end
        end
        default: begin
          state_q <= cihlc_pkg::SEQ_RUN;
          t_q     <= cihlc_pkg::T_FIRST;
        end
      endcase
    end
  end

  // nmi edge latch; a new edge in the take cycle wins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_pend_q <= 1'b0;
    end else if (rise[cihlc_pkg::IX_NMI]) begin
      nmi_pend_q <= 1'b1;
    end else if (nmi_take) begin
      nmi_pend_q <= 1'b0;
    end
  end

  // interrupt enable flag
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      if_q        <= 1'b0;
      pushed_if_q <= 1'b0;
    end else if (nmi_take || maskable_request_in_take) begin
      pushed_if_q <= if_q;
      if_q        <= 1'b0;
    end else if (flags_pop) begin
      if_q <= popped_if;
    end else if (if_set) begin
      if_q <= 1'b1;
    end else if (if_clear) begin
      if_q <= 1'b0;
    end
  end

  // vector type and table pointer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_valid_q <= 1'b0;
      irq_type_q  <= 8'h00;
      vec_ptr_q   <= 10'h000;
    end else begin
      irq_valid_q <= 1'b0;
      if (nmi_take) begin
        irq_valid_q <= 1'b1;
        irq_type_q  <= cihlc_pkg::NMI_TYPE;
        vec_ptr_q   <= vec_of(cihlc_pkg::NMI_TYPE);
      end else if (state_q == cihlc_pkg::SEQ_ACK2 && t_q == cihlc_pkg::T_READ) begin
        irq_type_q  <= bus.data_low;
        vec_ptr_q   <= vec_of(bus.data_low);
      end else if (state_q == cihlc_pkg::SEQ_ACK2 && t_q == cihlc_pkg::T_LAST) begin
        irq_valid_q <= 1'b1;
      end
    end
  end

  // halt indication, reissued after a hold ends inside halt
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ind_pend_q <= 1'b0;
    end else if (state_q == cihlc_pkg::SEQ_RUN && halt_exec && !maskable_request_in_take && !nmi_take) begin
      ind_pend_q <= 1'b1;
    end else if (state_q == cihlc_pkg::SEQ_HALT && hold_ack_q && !lvl[cihlc_pkg::IX_HOLD]) begin
      ind_pend_q <= 1'b1;
    end else if (halt_ind || state_q != cihlc_pkg::SEQ_HALT) begin
      ind_pend_q <= 1'b0;
    end
  end

  // local bus hold, never granted inside the acknowledge pair
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_ack_q <= 1'b0;
    end else if (hold_ack_q) begin
      hold_ack_q <= lvl[cihlc_pkg::IX_HOLD];
    end else begin
      hold_ack_q <= lvl[cihlc_pkg::IX_HOLD] && !ack_busy && !maskable_request_in_take && !rg_gr_q;
    end
  end

  // request/grant pin; own pulses are masked by the guard count
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rg_pend_q  <= 1'b0;
      rg_gr_q    <= 1'b0;
      rg_pulse_q <= 1'b0;
      guard_q    <= 3'h0;
    end else begin
      rg_pulse_q <= 1'b0;
      if (guard_q != 3'h0) begin
        guard_q <= guard_q - 3'h1;
      end
      if (rg_edge && rg_gr_q) begin
        rg_gr_q <= 1'b0;
      end else if (rg_edge) begin
        rg_pend_q <= 1'b1;
      end else if (rg_pend_q && !lock_active && !lock_prefix && !ack_busy && !hold_ack_q
                   && !maskable_request_in_take) begin
        rg_pend_q  <= 1'b0;
        rg_gr_q    <= 1'b1;
        rg_pulse_q <= 1'b1;
        guard_q    <= cihlc_pkg::RG_GUARD;
      end
    end
  end

  // lock from the prefix and from the acknowledge pair
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_pref_q <= 1'b0;
      lock_ack_q  <= 1'b0;
    end else begin
      if (lock_prefix) begin
        lock_pref_q <= 1'b1;
      end else if (lock_done) begin
        lock_pref_q <= 1'b0;
      end
      if (state_q == cihlc_pkg::SEQ_ACK1 && t_q == cihlc_pkg::T_FIRST) begin
        lock_ack_q <= 1'b1;
      end else if (state_q == cihlc_pkg::SEQ_ACK2 && t_q == cihlc_pkg::T_FIRST) begin
        lock_ack_q <= 1'b0;
      end
    end
  end

  // wait suspension on the test input
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      waiting_q <= 1'b0;
    end else if (nmi_take || maskable_request_in_take || !lvl[cihlc_pkg::IX_TEST]) begin
      waiting_q <= 1'b0;
    end else if (wait_exec) begin
      waiting_q <= 1'b1;
    end
  end

  assign bus.addr_latch_strobe = min_q && (halt_ind || (ack_busy && t_q == cihlc_pkg::T_FIRST));
  assign bus.cycle_status_code = min_q ? cihlc_pkg::ST_PASSIVE :
                                 (ack_busy && t_q != cihlc_pkg::T_LAST) ? cihlc_pkg::ST_INTERRUPT_ACK_STROBE :
                                 halt_ind ? cihlc_pkg::ST_HALT : cihlc_pkg::ST_PASSIVE;
  assign bus.interrupt_ack_strobe_n = !(min_q && ack_busy &&
                                        (t_q == cihlc_pkg::T_STRB || t_q == cihlc_pkg::T_READ));
  assign bus.lock_n    = !lock_active;
  assign bus.hold_ack  = hold_ack_q;
  assign bus.rg_cpu_o  = 1'b0;
  assign bus.rg_cpu_oe = rg_pulse_q;
  assign irq_valid     = irq_valid_q;
  assign irq_type      = irq_type_q;
  assign vec_ptr       = vec_ptr_q;
  assign pushed_if     = pushed_if_q;
  assign if_flag       = if_q;
  assign halted        = (state_q == cihlc_pkg::SEQ_HALT);
  assign waiting       = waiting_q;
  assign bus_released  = hold_ack_q || rg_gr_q;
endmodule // cihlc_cpu_end
`default_nettype wire

// [core/cihlc_ext_end.sv]
`timescale 1ns/1ps
`default_nettype none
module cihlc_ext_end (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  cihlc_if.ext            bus,
  input  wire logic       nmi_level,
  input  wire logic       irq_level,
  input  wire logic [7:0] irq_type,
  input  wire logic       hold_want,
  input  wire logic       rg_want,
  input  wire logic       test_block,
  input  wire logic       test_release,
  output logic            hold_granted,
  output logic            rg_granted,
  output logic            ack_done
);
  logic       nmi_q;
  logic [1:0] nmi_cnt_q;
  logic       maskable_request_in_q;
  logic       hold_q;
  logic       strb_prev_q;
  logic       phase_q;
  logic [7:0] data_q;
  logic       ack_done_q;
  logic       rg_pulse_q;
  logic       rg_hold_q;
  logic       stat_ack_q;
  logic       ack_low;
  logic       rg_wait_q;
  logic       rg_own_q;
  logic       rg_want_q;
  logic [2:0] test_cnt_q;
  logic       test_n_q;
  logic       strb_fall;
  logic       strb_rise;

  // nmi stretched past the least high time, driven from a flop so it is spike free
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      nmi_q     <= 1'b0;
      nmi_cnt_q <= 2'h0;
    end else if (nmi_level && !nmi_q) begin
      nmi_q     <= 1'b1;
      nmi_cnt_q <= cihlc_pkg::NMI_MIN_HIGH;
    end else if (nmi_cnt_q != 2'h0) begin
      nmi_cnt_q <= nmi_cnt_q - 2'h1;
    end else begin
      nmi_q     <= nmi_level;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      maskable_request_in_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      maskable_request_in_q <= irq_level;
      hold_q <= hold_want;
    end
  end

  // max mode has no strobe pin: ack status in its second and third state stands in for it
  assign ack_low   = !bus.interrupt_ack_strobe_n ||
                     ((bus.cycle_status_code == cihlc_pkg::ST_INTERRUPT_ACK_STROBE) && stat_ack_q);
  assign strb_fall = strb_prev_q && ack_low;
  assign strb_rise = !strb_prev_q && !ack_low;

  // type byte answered on the second acknowledge strobe only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      strb_prev_q <= 1'b1;
      stat_ack_q  <= 1'b0;
      phase_q     <= 1'b0;
      data_q      <= 8'h00;
      ack_done_q  <= 1'b0;
    end else begin
      strb_prev_q <= !ack_low;
      stat_ack_q  <= (bus.cycle_status_code == cihlc_pkg::ST_INTERRUPT_ACK_STROBE);
      ack_done_q  <= strb_rise && phase_q;
      if (strb_fall) begin
        data_q <= phase_q ? irq_type : 8'h00;
      end else if (strb_rise) begin
        phase_q <= !phase_q;
        data_q  <= 8'h00;
      end
    end
  end

  // request/grant: request pulse, wait for the grant pulse, release pulse
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rg_pulse_q <= 1'b0;
      rg_hold_q  <= 1'b0;
      rg_wait_q  <= 1'b0;
      rg_own_q   <= 1'b0;
      rg_want_q  <= 1'b0;
    end else begin
      rg_want_q  <= rg_want;
      rg_hold_q  <= rg_pulse_q;
      rg_pulse_q <= 1'b0;
      if (rg_want && !rg_want_q && !rg_own_q && !rg_wait_q) begin
        rg_pulse_q <= 1'b1;
        rg_wait_q  <= 1'b1;
      end else if (rg_wait_q && !rg_pulse_q && !rg_hold_q && !bus.request_grant_pin) begin
        rg_wait_q  <= 1'b0;
        rg_own_q   <= 1'b1;
      end else if (!rg_want && rg_want_q && rg_own_q) begin
        rg_pulse_q <= 1'b1;
        rg_own_q   <= 1'b0;
      end
    end
  end

  // test held low for the least time after a release request
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      test_cnt_q <= 3'h0;
      test_n_q   <= 1'b1;
    end else begin
      if (test_release) begin
        test_cnt_q <= cihlc_pkg::TEST_MIN_LOW;
      end else if (test_cnt_q != 3'h0) begin
        test_cnt_q <= test_cnt_q - 3'h1;
      end
      test_n_q <= test_block && !test_release && (test_cnt_q <= 3'h1);
    end
  end

  assign bus.nmi                 = nmi_q;
  assign bus.maskable_request_in = maskable_request_in_q;
  assign bus.hold_req            = hold_q;
  assign bus.data_low            = data_q;
  assign bus.test_n              = test_n_q;
  assign bus.rg_ext_o            = 1'b0;
  // two clocks low, or the three-flop filter at the processor end drops the pulse
  assign bus.rg_ext_oe           = rg_pulse_q || rg_hold_q;
  assign hold_granted            = bus.hold_ack;
  assign rg_granted              = rg_own_q;
  assign ack_done                = ack_done_q;
endmodule // cihlc_ext_end
`default_nettype wire

// [shared/cihlc_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface cihlc_if;
  logic       nmi;
  logic       maskable_request_in;
  logic       interrupt_ack_strobe_n;
  logic [7:0] data_low;
  logic       lock_n;
  logic [2:0] cycle_status_code;
  logic       addr_latch_strobe;
  logic       hold_req;
  logic       hold_ack;
  logic       test_n;
  logic       rg_cpu_o;
  logic       rg_cpu_oe;
  logic       rg_ext_o;
  logic       rg_ext_oe;
  logic       request_grant_pin;

  // open-drain style wire with pull-up
  assign request_grant_pin = rg_cpu_oe ? rg_cpu_o : (rg_ext_oe ? rg_ext_o : 1'b1);

  modport cpu (
    input  nmi, maskable_request_in, data_low, hold_req, test_n, request_grant_pin,
    output interrupt_ack_strobe_n, lock_n, cycle_status_code, addr_latch_strobe,
    output hold_ack, rg_cpu_o, rg_cpu_oe
  );
  modport ext (
    output nmi, maskable_request_in, data_low, hold_req, test_n, rg_ext_o, rg_ext_oe,
    input  interrupt_ack_strobe_n, lock_n, cycle_status_code, addr_latch_strobe,
    input  hold_ack, request_grant_pin
  );
endinterface
`default_nettype wire

// [shared/cihlc_pkg.sv]
package cihlc_pkg;
  // vector table
  localparam int unsigned VEC_ENTRIES     = 256;
  localparam int unsigned VEC_ENTRY_BYTES = 4;
  localparam int unsigned VEC_SHIFT       = 2;
  localparam int unsigned TYPE_W          = 8;
  localparam int unsigned PTR_W           = 10;
  localparam logic [9:0]  VEC_TOP         = 10'h3FF;
  localparam logic [7:0]  NMI_TYPE        = 8'h02;
  // cycle status codes
  localparam logic [2:0]  ST_INTERRUPT_ACK_STROBE         = 3'h0;
  localparam logic [2:0]  ST_HALT         = 3'h3;
  localparam logic [2:0]  ST_PASSIVE      = 3'h7;
  // bus cycle clock states T1..T4
  localparam logic [1:0]  T_FIRST         = 2'h0;
  localparam logic [1:0]  T_STRB          = 2'h1;
  localparam logic [1:0]  T_READ          = 2'h2;
  localparam logic [1:0]  T_LAST          = 2'h3;
  // pin inputs of the processor end, with their idle levels
  localparam int unsigned IN_W            = 5;
  localparam int unsigned IX_NMI          = 0;
  localparam int unsigned IX_MASKABLE_REQUEST_IN         = 1;
  localparam int unsigned IX_HOLD         = 2;
  localparam int unsigned IX_RG           = 3;
  localparam int unsigned IX_TEST         = 4;
  localparam logic [4:0]  IN_IDLE         = 5'h18;
  // timing in clock cycles at 100 MHz
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam logic [1:0]  NMI_MIN_HIGH    = 2'h2;
  localparam logic [2:0]  TEST_MIN_LOW    = 3'h5;
  localparam logic [2:0]  RG_GUARD        = 3'h6;

  typedef enum {
    SEQ_RUN,
    SEQ_ACK1,
    SEQ_ACK2,
    SEQ_HALT
  } cihlc_seq_type;
endpackage

// [test/cihlc_props.sv]
`timescale 1ns/1ps
`default_nettype none
module cihlc_props (
  input wire logic       sys_clk,
  input wire logic       arst_n,
  input wire logic       interrupt_ack_strobe_n,
  input wire logic       lock_n,
  input wire logic [2:0] cycle_status_code,
  input wire logic       addr_latch_strobe,
  input wire logic       hold_ack,
  input wire logic       rg_cpu_oe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  strobe_width_a: assert property (
    $fell(interrupt_ack_strobe_n) |=> !interrupt_ack_strobe_n ##1 interrupt_ack_strobe_n)
    else $error("ack strobe not two cycles low");
  ale_first_a: assert property (
    $fell(interrupt_ack_strobe_n) |-> $past(addr_latch_strobe))
    else $error("ack strobe without latch strobe before it");
  ack_status_a: assert property (
    $rose(cycle_status_code == cihlc_pkg::ST_INTERRUPT_ACK_STROBE) |=>
      (cycle_status_code == cihlc_pkg::ST_INTERRUPT_ACK_STROBE) [*2] ##1
      (cycle_status_code == cihlc_pkg::ST_PASSIVE))
    else $error("ack status not three cycles");
  ack_lock_span_a: assert property (
    $fell(interrupt_ack_strobe_n) && $fell(lock_n) |->
      ##4 ($fell(interrupt_ack_strobe_n) && $rose(lock_n)))
    else $error("lock not held first to second ack");
  hold_defer_a: assert property (
    (!interrupt_ack_strobe_n || cycle_status_code == cihlc_pkg::ST_INTERRUPT_ACK_STROBE) |-> !$rose(hold_ack))
    else $error("hold granted inside ack pair");
  rg_lock_a: assert property (
    !lock_n |-> !rg_cpu_oe)
    else $error("grant given while locked");
  ale_single_a: assert property (
    addr_latch_strobe |=> !addr_latch_strobe)
    else $error("latch strobe longer than one cycle");
  halt_pulse_a: assert property (
    cycle_status_code == cihlc_pkg::ST_HALT |=> cycle_status_code == cihlc_pkg::ST_PASSIVE)
    else $error("halt status longer than one cycle");
  min_status_a: assert property (
    (addr_latch_strobe || !interrupt_ack_strobe_n) |-> cycle_status_code == cihlc_pkg::ST_PASSIVE)
    else $error("status active in minimum mode");
  halt_hold_a: assert property (
    hold_ack |-> cycle_status_code != cihlc_pkg::ST_HALT && !addr_latch_strobe)
    else $error("halt indication while hold granted");
endmodule // cihlc_props
`default_nettype wire

// [test/cihlc_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module cihlc_tb;
  logic       sys_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       strap = 1'b1;
  logic       bnd = 1'b0;
  logic [8:0] pl = 9'h000;
  logic       popped_if = 1'b0;
  logic       nmi_level = 1'b0;
  logic       irq_level = 1'b0;
  logic [7:0] req_type = 8'h00;
  logic       hold_want = 1'b0;
  logic       rg_want = 1'b0;
  logic       test_block = 1'b0;
  logic       irq_valid, pushed_if, if_flag, halted, waiting;
  logic [7:0] irq_type;
  logic [9:0] vec_ptr;
  logic       hold_granted, rg_granted, ack_done;
  logic       bus_rel;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         seed = 16;
  int         acks = 0;
  int         irqs = 0;
  int         n0;

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (ack_done === 1'b1) acks <= acks + 1;
    if (irq_valid === 1'b1) irqs <= irqs + 1;
  end

  cihlc_if bus ();
  cihlc_cpu_end u_cihlc_cpu_end (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus),
    .min_mode_strap(strap), .boundary(bnd), .lock_prefix(pl[1]), .lock_done(pl[2]),
    .halt_exec(pl[3]), .wait_exec(pl[4]), .if_set(pl[5]), .if_clear(pl[6]),
    .flags_pop(pl[7]), .popped_if(popped_if), .irq_valid(irq_valid), .irq_type(irq_type),
    .vec_ptr(vec_ptr), .pushed_if(pushed_if), .if_flag(if_flag), .halted(halted),
    .waiting(waiting), .bus_released(bus_rel));
  cihlc_ext_end u_cihlc_ext_end (.sys_clk(sys_clk), .arst_n(arst_n), .bus(bus),
    .nmi_level(nmi_level), .irq_level(irq_level), .irq_type(req_type),
    .hold_want(hold_want), .rg_want(rg_want), .test_block(test_block),
    .test_release(pl[8]), .hold_granted(hold_granted), .rg_granted(rg_granted),
    .ack_done(ack_done));
  cihlc_props u_cihlc_props (.sys_clk(sys_clk), .arst_n(arst_n),
    .interrupt_ack_strobe_n(bus.interrupt_ack_strobe_n), .lock_n(bus.lock_n),
    .cycle_status_code(bus.cycle_status_code), .addr_latch_strobe(bus.addr_latch_strobe),
    .hold_ack(bus.hold_ack), .rg_cpu_oe(bus.rg_cpu_oe));

  function automatic logic [9:0] exp_ptr(input logic [7:0] t);
    return {t, 2'b00};
  endfunction

  task automatic test_done();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [9:0] e, input logic [9:0] a);
    samples_checked++;
    if (a !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t value exp %h got %h", $time, e, a);
    end
  endtask

  task automatic chk_bit(input logic e, input logic a);
    samples_checked++;
    if (a !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t flag exp %b got %b", $time, e, a);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic pulse(input int i);
    @(posedge sys_clk);
    pl[i] <= 1'b1;
    @(posedge sys_clk);
    pl[i] <= 1'b0;
    #1;
  endtask

  task automatic wait_on(input int sel, input int lim);
    logic seen;
    seen = 1'b0;
    for (int k = 0; k < lim && !seen; k++) begin
      cyc(1);
      case (sel)
        0: seen = (irq_valid === 1'b1);
        1: seen = (rg_granted === 1'b1);
        2: seen = (hold_granted === 1'b1);
        default: seen = (waiting === 1'b0);
      endcase
    end
    if (!seen) begin
      fail_count++;
      $display("MISMATCH t=%0t wait limit %0d", $time, sel);
      test_done();
    end
  endtask

  task automatic run_irq(input logic [7:0] t);
    int a0;
    a0 = acks;
    pulse(5);
    @(posedge sys_clk);
    req_type <= t;
    irq_level <= 1'b1;
    wait_on(0, 60);
    chk_val(exp_ptr(t), vec_ptr);
    chk_val({2'h0, t}, {2'h0, irq_type});
    chk_bit(1'b0, if_flag);
    chk_bit(1'b1, pushed_if);
    @(posedge sys_clk);
    irq_level <= 1'b0;
    // let the filtered request fall before the next enable, or it is served again
    cyc(6);
    chk_val(10'(a0 + 1), 10'(acks));
  endtask

  initial begin
    for (int m = 1; m >= 0; m--) begin
      @(posedge sys_clk);
      arst_n <= 1'b0;
      strap <= m[0];
      bnd <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      bnd <= 1'b1;
      // both requests at once, then a second edge
      pulse(5);
      @(posedge sys_clk);
      nmi_level <= 1'b1;
      irq_level <= 1'b1;
      req_type <= 8'h5A;
      wait_on(0, 40);
      chk_val({2'h0, cihlc_pkg::NMI_TYPE}, {2'h0, irq_type});
      chk_val(10'h008, vec_ptr);
      chk_bit(1'b0, if_flag);
      // the pulse just seen is counted at the next edge
      n0 = irqs + 1;
      @(posedge sys_clk);
      irq_level <= 1'b0;
      cyc(20);
      chk_val(10'(n0), 10'(irqs));
      @(posedge sys_clk);
      nmi_level <= 1'b0;
      cyc(6);
      @(posedge sys_clk);
      nmi_level <= 1'b1;
      wait_on(0, 40);
      chk_val(10'h008, vec_ptr);
      @(posedge sys_clk);
      nmi_level <= 1'b0;
      cyc(6);
      for (int i = 0; i < 6; i++) begin
        run_irq(i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed)));
      end
      // masked request, then flags pop reopens it
      pulse(6);
      @(posedge sys_clk);
      irq_level <= 1'b1;
      req_type <= 8'h3C;
      n0 = irqs;
      cyc(30);
      chk_val(10'(n0), 10'(irqs));
      @(posedge sys_clk);
      popped_if <= 1'b1;
      pulse(7);
      chk_bit(1'b1, if_flag);
      wait_on(0, 60);
      chk_val(exp_ptr(8'h3C), vec_ptr);
      @(posedge sys_clk);
      irq_level <= 1'b0;
      popped_if <= 1'b0;
      // halt across a hold, left by an edge request
      pulse(3);
      chk_bit(1'b1, halted);
      @(posedge sys_clk);
      hold_want <= 1'b1;
      wait_on(2, 20);
      chk_bit(1'b1, bus_rel);
      cyc(5);
      @(posedge sys_clk);
      hold_want <= 1'b0;
      cyc(12);
      chk_bit(1'b1, halted);
      @(posedge sys_clk);
      nmi_level <= 1'b1;
      wait_on(0, 40);
      cyc(1);
      chk_bit(1'b0, halted);
      @(posedge sys_clk);
      nmi_level <= 1'b0;
      // locked sequence with a request/grant arrival
      pulse(1);
      chk_bit(1'b0, bus.lock_n);
      @(posedge sys_clk);
      rg_want <= 1'b1;
      cyc(20);
      chk_bit(1'b0, rg_granted);
      pulse(2);
      wait_on(1, 30);
      chk_bit(1'b1, bus_rel);
      chk_bit(1'b1, bus.lock_n);
      @(posedge sys_clk);
      rg_want <= 1'b0;
      test_block <= 1'b1;
      cyc(15);
      // suspension on the test input
      pulse(4);
      chk_bit(1'b1, waiting);
      cyc(8);
      chk_bit(1'b1, waiting);
      pulse(8);
      wait_on(3, 20);
      @(posedge sys_clk);
      test_block <= 1'b0;
    end
    test_done();
  end
endmodule // cihlc_tb
`default_nettype wire
